/* File: design/dbg_trig_pkg.sv */
// Purpose: constants for the debug trigger and status block
// Assumes: 8-bit registers on a plain strobe port, one clock
// Notes: none
package dbg_trig_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [1:0] CONTROL_OFF = 2'h0;
    localparam logic [1:0] SETUP_OFF = 2'h1;
    localparam logic [1:0] FLAGS_OFF = 2'h2;
    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_ARM_BIT = 6;
    localparam int CTL_BREAK_BIT = 4;
    localparam int SETUP_QUAL_BIT = 7;
    localparam int SETUP_BEGIN_BIT = 6;
    localparam logic [7:0] SETUP_WMASK = 8'hCF;
    localparam int FLAG_A_BIT = 7;
    localparam int FLAG_B_BIT = 6;
    localparam int FLAG_ARM_BIT = 5;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [3:0] BUFFER_DEPTH = 4'h8;
    // ------------------------------------------------------------
    // trigger modes
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_A_ONLY = 4'h0;
    localparam logic [3:0] MODE_A_OR_B = 4'h1;
    localparam logic [3:0] MODE_A_THEN_B = 4'h2;
    localparam logic [3:0] MODE_EVENT_B = 4'h3;
    localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
    localparam logic [3:0] MODE_A_AND_B = 4'h5;
    localparam logic [3:0] MODE_A_AND_NOT_B = 4'h6;
    localparam logic [3:0] MODE_INSIDE = 4'h7;
    localparam logic [3:0] MODE_OUTSIDE = 4'h8;
endpackage

/* File: design/trigger_decode.sv */
// Purpose: combinational trigger condition decode per mode
// Assumes: comparator hits are qualified already
// Notes: sequential A-then-B state kept by caller
module trigger_decode
    import dbg_trig_pkg::*;
(
    input wire logic [3:0] trigger_mode_code,
    input wire logic hit_a,
    input wire logic hit_b,
    input wire logic data_b,
    input wire logic addr_ge_a,
    input wire logic addr_le_b,
    input wire logic a_seen,
    output logic trigger,
    output logic event_only
);
    always_comb begin
        trigger = 1'b0;
        event_only = 1'b0;
        case (trigger_mode_code)
            MODE_A_ONLY: trigger = hit_a;
            MODE_A_OR_B: trigger = hit_a | hit_b;
            MODE_A_THEN_B: trigger = a_seen & hit_b;
            MODE_EVENT_B: begin
                trigger = hit_b;
                event_only = 1'b1;
            end
            MODE_A_THEN_EVENT_B: begin
                trigger = a_seen & hit_b;
                event_only = 1'b1;
            end
            MODE_A_AND_B: trigger = hit_a & data_b;
            MODE_A_AND_NOT_B: trigger = hit_a & ~data_b;
            MODE_INSIDE: trigger = addr_ge_a & addr_le_b;
            MODE_OUTSIDE: trigger = ~addr_ge_a | ~addr_le_b;
            default: trigger = 1'b0;
        endcase
    end
endmodule

/* File: design/debug_trigger_status.sv */
// Purpose: debug trigger setup, run control and status flags
// Assumes: comparator and buffer logic outside; one bus clock
// Notes: registers reached over a plain strobe port
//
// The plain strobed port and the register addresses were chosen for this implementation.
module debug_trigger_status
    import dbg_trig_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic cmp_a_match,
    input wire logic cmp_b_match,
    input wire logic cmp_b_data_match,
    input wire logic addr_ge_a,
    input wire logic addr_le_b,
    input wire logic opcode_exec_a,
    input wire logic opcode_exec_b,
    input wire logic word_store,
    output logic capture_en,
    output logic run_active,
    output logic break_req
);
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] setup;
        logic flag_a;
        logic flag_b;
        logic a_seen;
        logic started;
        logic [3:0] count;
        logic [7:0] rdata;
        logic brk;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic hit_a;
    logic hit_b;
    logic trig;
    logic event_only;
    logic armed;
    logic begin_trace;
    logic full;

    function automatic logic qualify(input logic m, input logic ex, input logic tag);
        qualify = tag ? (m & ex) : m;
    endfunction

    // ------------------------------------------------------------
    // trigger conditions
    // ------------------------------------------------------------
    assign hit_a = qualify(cmp_a_match, opcode_exec_a, st_r.setup[SETUP_QUAL_BIT]);
    assign hit_b = qualify(cmp_b_match, opcode_exec_b, st_r.setup[SETUP_QUAL_BIT]);

    trigger_decode u_decode (
        .trigger_mode_code(st_r.setup[3:0]),
        .hit_a(hit_a),
        .hit_b(hit_b),
        .data_b(cmp_b_data_match),
        .addr_ge_a(addr_ge_a),
        .addr_le_b(addr_le_b),
        .a_seen(st_r.a_seen | hit_a),
        .trigger(trig),
        .event_only(event_only)
    );

    assign armed = st_r.control[CTL_ENABLE_BIT] & st_r.control[CTL_ARM_BIT];
    assign begin_trace = event_only | st_r.setup[SETUP_BEGIN_BIT];
    assign full = (st_r.count == BUFFER_DEPTH);
    assign capture_en = armed & (begin_trace ? st_r.started : 1'b1) & ~full;
    assign run_active = armed;
    assign break_req = st_r.brk;
    assign reg_rdata = st_r.rdata;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic done;
        logic arm_start;
        done = 1'b0;
        arm_start = 1'b0;
        st_nxt = st_r;
        st_nxt.brk = 1'b0;
        st_nxt.rdata = 8'h00;
        if (armed) begin
            if (hit_a) begin
                st_nxt.flag_a = 1'b1;
                st_nxt.a_seen = 1'b1;
            end
            if (hit_b) begin
                st_nxt.flag_b = 1'b1;
            end
            if (trig) begin
                st_nxt.started = 1'b1;
            end
            if (capture_en && word_store) begin
                if (!begin_trace && full) begin
                    st_nxt.count = st_r.count;
                end else begin
                    st_nxt.count = st_r.count + 4'h1;
                end
            end
            if (!begin_trace && word_store && st_r.count != BUFFER_DEPTH) begin
                st_nxt.count = st_r.count + 4'h1;
            end
            if (begin_trace && capture_en && word_store && st_r.count == BUFFER_DEPTH - 4'h1) begin
                done = 1'b1;
            end
            if (!begin_trace && trig) begin
                done = 1'b1;
            end
            if (done) begin
                st_nxt.control[CTL_ARM_BIT] = 1'b0;
                st_nxt.brk = st_r.control[CTL_BREAK_BIT];
            end
        end
        // register writes
        if (reg_wr) begin
            case (reg_addr)
                CONTROL_OFF: begin
                    arm_start = reg_wdata[CTL_ARM_BIT] & reg_wdata[CTL_ENABLE_BIT]
                        & ~armed;
                    st_nxt.control = reg_wdata;
                end
                SETUP_OFF: begin
                    if (!st_r.control[CTL_ARM_BIT]) begin
                        st_nxt.setup = reg_wdata & SETUP_WMASK;
                    end
                end
                default: begin
                    st_nxt.control = st_nxt.control;
                end
            endcase
        end
        if (arm_start) begin
            st_nxt.flag_a = 1'b0;
            st_nxt.flag_b = 1'b0;
            st_nxt.a_seen = 1'b0;
            st_nxt.started = 1'b0;
            st_nxt.count = 4'h0;
        end
        // register reads; buffer reads leave count alone
        if (reg_rd) begin
            case (reg_addr)
                CONTROL_OFF: st_nxt.rdata = st_r.control;
                SETUP_OFF: st_nxt.rdata = st_r.setup & SETUP_WMASK;
                FLAGS_OFF: st_nxt.rdata = {st_r.flag_a, st_r.flag_b, armed, 1'b0,
                    st_r.count};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{control: CONTROL_RESET, setup: SETUP_RESET, flag_a: 1'b0,
                flag_b: 1'b0, a_seen: 1'b0, started: 1'b0, count: 4'h0,
                rdata: 8'h00, brk: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

/* File: verif/dbg_trig_checker.sv */
// Purpose: port assertions for the debug trigger block
// Assumes: one clock, async active-low reset
// Notes: bound from the testbench
module dbg_trig_checker
    import dbg_trig_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic cmp_a_match,
    input wire logic cmp_b_match,
    input wire logic capture_en,
    input wire logic run_active,
    input wire logic break_req
);
    wire ctl_wr = reg_wr && reg_addr == CONTROL_OFF;
    wire quiet = !cmp_a_match && !cmp_b_match;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence start_s;
        ctl_wr && reg_wdata[7:6] == 2'h3 && !run_active && quiet;
    endsequence
    sequence flag_rd_s;
        reg_rd && reg_addr == FLAGS_OFF;
    endsequence
    setup_zero_a: assert property (reg_rd && reg_addr == SETUP_OFF |=> !reg_rdata[5:4])
        else $error("setup bits 5:4 set");
    run_start_a: assert property (start_s |=> run_active)
        else $error("run did not start");
    start_clear_a: assert property (start_s ##1 quiet ##1 flag_rd_s |=> !(reg_rdata & 8'hCF))
        else $error("flags not cleared at start");
    armed_mirror_a: assert property (flag_rd_s |=> reg_rdata[5] == $past(run_active))
        else $error("armed flag wrong");
    abort_a: assert property (ctl_wr && reg_wdata[7:6] != 2'h3 |=> !run_active)
        else $error("run not ended");
    count_max_a: assert property (flag_rd_s |=> reg_rdata[3:0] <= BUFFER_DEPTH)
        else $error("count above depth");
    break_one_a: assert property (break_req |=> !break_req)
        else $error("break longer than one cycle");
    capture_off_a: assert property (!run_active |-> !capture_en)
        else $error("capture while idle");
endmodule

/* File: verif/bus_watch_model.sv */
// Purpose: bus-side model giving comparator hits and trace stores
// Assumes: bench sets one request vector per cycle
// Notes: a request shows for one cycle after the edge that takes it
module bus_watch_model (
    input wire logic sys_clk,
    input wire logic [7:0] req,
    output logic [7:0] hits
);
    // order: store, a, b, b data, ge a, le b, exec a, exec b
    always_ff @(posedge sys_clk) begin
        hits <= req;
    end
endmodule

/* File: verif/debug_trigger_status_tb.sv */
// Purpose: self-checking bench for the debug trigger block
// Assumes: 25 MHz clock, reset held 12 cycles
// Notes: one task per scenario
module debug_trigger_status_tb
    import dbg_trig_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] req = 8'h00;
    logic [7:0] hits;
    logic [7:0] reg_rdata;
    logic cmp_a_match, cmp_b_match, cmp_b_data_match, addr_ge_a, addr_le_b;
    logic opcode_exec_a, opcode_exec_b, word_store, capture_en, run_active, break_req;
    int mismatches = 0;
    int comparisons = 0;
    assign {word_store, cmp_a_match, cmp_b_match, cmp_b_data_match, addr_ge_a, addr_le_b,
        opcode_exec_a, opcode_exec_b} = hits;
    debug_trigger_status debug_trigger_status_inst (.sys_clk, .rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .cmp_a_match, .cmp_b_match, .cmp_b_data_match,
        .addr_ge_a, .addr_le_b, .opcode_exec_a, .opcode_exec_b, .word_store, .capture_en,
        .run_active, .break_req);
    bus_watch_model bus_watch_model_inst (.sys_clk, .req, .hits);
    initial forever #20 sys_clk = ~sys_clk;
    task automatic complete_run();
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // write, or read and compare with d
    task automatic bus(logic w, logic [1:0] a, logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 if (!w) check(reg_rdata, d);
    endtask
    task automatic drive(logic [7:0] v, int n);
        repeat (n) begin
            @(posedge sys_clk);
            req <= v;
            @(posedge sys_clk);
            req <= 8'h00;
        end
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic s_regs();
        bus(1'b0, SETUP_OFF, SETUP_RESET);
        bus(1'b1, SETUP_OFF, 8'hFF);
        bus(1'b0, SETUP_OFF, 8'hCF);
        bus(1'b1, CONTROL_OFF, 8'hC0);
        bus(1'b1, SETUP_OFF, 8'h00);
        bus(1'b0, SETUP_OFF, 8'hCF);
        bus(1'b1, FLAGS_OFF, 8'hFF);
        bus(1'b0, FLAGS_OFF, 8'h20);
        bus(1'b1, CONTROL_OFF, 8'h80);
        bus(1'b0, FLAGS_OFF, 8'h00);
    endtask
    task automatic s_end();
        bus(1'b1, SETUP_OFF, 8'h00);
        bus(1'b1, CONTROL_OFF, 8'hD0);
        drive(8'h80, 10);
        check({7'h00, run_active}, 8'h01);
        drive(8'h40, 1);
        for (int i = 0; i < 10 && break_req !== 1'b1; i++) @(negedge sys_clk);
        check({7'h00, break_req}, 8'h01);
        if (break_req !== 1'b1) complete_run();
        bus(1'b0, FLAGS_OFF, 8'h88);
        bus(1'b0, CONTROL_OFF, 8'h90);
    endtask
    task automatic s_begin();
        bus(1'b1, SETUP_OFF, 8'h03);
        bus(1'b1, CONTROL_OFF, 8'hC0);
        bus(1'b0, FLAGS_OFF, 8'h20);
        drive(8'h80, 3);
        drive(8'h20, 1);
        drive(8'h80, 7);
        check({7'h00, run_active}, 8'h01);
        drive(8'h80, 1);
        check({7'h00, run_active}, 8'h00);
        bus(1'b0, FLAGS_OFF, 8'h48);
        bus(1'b0, FLAGS_OFF, 8'h48);
    endtask
    task automatic s_modes();
        bus(1'b1, SETUP_OFF, 8'h80);
        bus(1'b1, CONTROL_OFF, 8'hC0);
        drive(8'h40, 1);
        check({7'h00, run_active}, 8'h01);
        drive(8'h42, 1);
        check({7'h00, run_active}, 8'h00);
        bus(1'b1, SETUP_OFF, 8'h07);
        bus(1'b1, CONTROL_OFF, 8'hC0);
        drive(8'h08, 1);
        check({7'h00, run_active}, 8'h01);
        drive(8'h0C, 1);
        check({7'h00, run_active}, 8'h00);
        bus(1'b1, SETUP_OFF, 8'h05);
        bus(1'b1, CONTROL_OFF, 8'hC0);
        drive(8'h40, 1);
        check({7'h00, run_active}, 8'h01);
        drive(8'h50, 1);
        check({7'h00, run_active}, 8'h00);
    endtask
    task automatic s_none();
        bus(1'b1, SETUP_OFF, 8'h09);
        bus(1'b1, CONTROL_OFF, 8'hC0);
        drive(8'hFF, 2);
        check({7'h00, run_active}, 8'h01);
        bus(1'b1, CONTROL_OFF, 8'h40);
        check({7'h00, run_active}, 8'h00);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        s_regs();
        s_end();
        s_begin();
        s_modes();
        s_none();
        complete_run();
    end
endmodule
bind debug_trigger_status dbg_trig_checker dbg_trig_checker_inst (.sys_clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmp_a_match, .cmp_b_match,
    .capture_en, .run_active, .break_req);
